/* rtl/rtcsra_top.sv */
`timescale 1ns/10ps
module rtcsra_top
(
  // clock and reset
  input  wire logic       SYS_CLK,
  input  wire logic       SRST,
  // serial bus pins (data is open drain)
  input  wire logic       SCL_IN,
  input  wire logic       SDA_IN,
  output logic            SDA_OUT,
  output logic            SDA_OE,
  // write stream toward the register array, two-entry buffered
  output logic            WR_VALID,
  input  wire logic       WR_READY,
  output logic [7:0]      WR_ADDR,
  output logic [7:0]      WR_DATA,
  // register array read port, combinational from the pointer
  output logic [7:0]      RD_ADDR,
  input  wire logic [7:0] RD_DATA
);
  typedef struct packed {
    logic [2:0]            scl_s;
    logic [2:0]            sda_s;
    logic                  scl_f;
    logic                  sda_f;
    rtcsra_pkg::rtcsra_state_t st;
    logic [3:0]            bcnt;
    logic [7:0]            shf;
    logic                  rd_dir;
    logic                  ack_slot;
    logic                  sda_oe;
    logic [7:0]            ptr;
    logic [7:0]            waddr;
    logic [1:0]            bv;
    logic [15:0]           b0;
    logic [15:0]           b1;
  } rtcsra_reg_t;

  rtcsra_reg_t q;
  rtcsra_reg_t d;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic [7:0] byte_in;
  logic [7:0] ptr_inc;

  // filtered levels change only when the second and third stages agree
  assign scl_rise = (q.scl_s[1] == q.scl_s[2]) && q.scl_s[2] && !q.scl_f;
  assign scl_fall = (q.scl_s[1] == q.scl_s[2]) && !q.scl_s[2] && q.scl_f;
  assign start_c  = (q.sda_s[1] == q.sda_s[2]) && !q.sda_s[2] && q.sda_f && q.scl_f && q.scl_s[2];
  assign stop_c   = (q.sda_s[1] == q.sda_s[2]) && q.sda_s[2] && !q.sda_f && q.scl_f && q.scl_s[2];
  assign byte_in  = {q.shf[6:0], q.sda_f};
  assign ptr_inc  = (q.ptr == rtcsra_pkg::PTR_LAST) ? rtcsra_pkg::PTR_RESET : 8'(q.ptr + 8'h01);

  // next state: synchronisers, bus engine and write buffer
  always_comb
  begin
    d = q;
    d.scl_s = {q.scl_s[1:0], SCL_IN};
    d.sda_s = {q.sda_s[1:0], SDA_IN};
    if (q.scl_s[1] == q.scl_s[2])
      d.scl_f = q.scl_s[2];
    if (q.sda_s[1] == q.sda_s[2])
      d.sda_f = q.sda_s[2];
    // drain side of the buffer
    if (q.bv[0] && WR_READY)
    begin
      d.b0 = q.b1;
      d.bv = {1'b0, q.bv[1]};
    end
    if (stop_c)
    begin
      d.st     = rtcsra_pkg::ST_IDLE;
      d.sda_oe = 1'b0;
    end
    else if (start_c)
    begin
      // a repeated start keeps the pointer loaded by the dummy write
      d.st       = rtcsra_pkg::ST_ID;
      d.bcnt     = rtcsra_pkg::BIT_RESET;
      d.ack_slot = 1'b0;
      d.sda_oe   = 1'b0;
    end
    // the controller's acknowledge slot is decided below, it must not be shifted in as a bit
    else if (scl_rise && q.st != rtcsra_pkg::ST_IDLE && !q.ack_slot && q.st != rtcsra_pkg::ST_RDAT
             && q.st != rtcsra_pkg::ST_RACK)
    begin
      d.shf  = byte_in;
      d.bcnt = 4'(q.bcnt + 4'h1);
    end
    else if (scl_rise && q.st == rtcsra_pkg::ST_RACK)
    begin
      // controller acknowledge decides whether another byte goes out
      d.st = q.sda_f ? rtcsra_pkg::ST_IDLE : rtcsra_pkg::ST_RDAT;
    end
    else if (scl_fall)
    begin
      if (q.ack_slot)
      begin
        // end of the ninth clock: release the line (after a read id, drive bit 7 of RD_DATA instead) and move on
        d.ack_slot = 1'b0;
        d.sda_oe   = 1'b0;
        d.bcnt     = rtcsra_pkg::BIT_RESET;
        if (q.st == rtcsra_pkg::ST_ID)
          d.st = q.rd_dir ? rtcsra_pkg::ST_RDAT : rtcsra_pkg::ST_ADDR;
        else if (q.st == rtcsra_pkg::ST_ADDR)
          d.st = rtcsra_pkg::ST_WDAT;
        else if (q.st == rtcsra_pkg::ST_WDAT)
          d.st = rtcsra_pkg::ST_IDLE;
        if (q.st == rtcsra_pkg::ST_ID && q.rd_dir)
        begin
          d.sda_oe = !RD_DATA[7];
          d.bcnt   = 4'h1;
        end
      end
      else if (q.st == rtcsra_pkg::ST_RDAT)
      begin
        if (q.bcnt == rtcsra_pkg::BIT_ACK)
        begin
          d.sda_oe = 1'b0;
          d.st     = rtcsra_pkg::ST_RACK;
          d.ptr    = ptr_inc;
          d.bcnt   = rtcsra_pkg::BIT_RESET;
        end
        else if (q.bcnt == rtcsra_pkg::BIT_RESET)
        begin
          d.sda_oe = !RD_DATA[7];
          d.bcnt   = 4'h1;
        end
        else
        begin
          d.sda_oe = !RD_DATA[3'(4'h7 - q.bcnt)];
          d.bcnt   = 4'(q.bcnt + 4'h1);
        end
      end
      else if (q.bcnt == rtcsra_pkg::BIT_ACK && q.st != rtcsra_pkg::ST_IDLE)
      begin
        unique case (q.st)
          rtcsra_pkg::ST_ID:
          begin
            if (q.shf[7:1] == rtcsra_pkg::TARGET_ID)
            begin
              d.ack_slot = 1'b1;
              d.sda_oe   = 1'b1;
              d.rd_dir   = q.shf[0];
            end
            else
              d.st = rtcsra_pkg::ST_IDLE;
          end
          rtcsra_pkg::ST_ADDR:
          begin
            d.ack_slot = 1'b1;
            d.sda_oe   = 1'b1;
            d.ptr      = q.shf;
            d.waddr    = q.shf;
          end
          rtcsra_pkg::ST_WDAT:
          begin
            // a full buffer withholds the acknowledge so no word is lost
            if (!d.bv[1])
            begin
              d.ack_slot = 1'b1;
              d.sda_oe   = 1'b1;
              if (d.bv[0])
              begin
                d.b1 = {q.waddr, q.shf};
                d.bv = 2'b11;
              end
              else
              begin
                d.b0 = {q.waddr, q.shf};
                d.bv = 2'b01;
              end
            end
            else
              d.st = rtcsra_pkg::ST_IDLE;
          end
          default:
            d.st = rtcsra_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // single register stage; the pointer clears on reset
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      q        <= '0;
      q.scl_s  <= 3'h7;
      q.sda_s  <= 3'h7;
      q.scl_f  <= 1'b1;
      q.sda_f  <= 1'b1;
      q.st     <= rtcsra_pkg::ST_IDLE;
      q.ptr    <= rtcsra_pkg::PTR_RESET;
    end
    else
      q <= d;
  end

  // outputs straight from flip-flops except SDA_OUT, tied low; read address output is the pointer register
  assign SDA_OUT  = 1'b0;
  assign SDA_OE   = q.sda_oe;
  assign WR_VALID = q.bv[0];
  assign WR_ADDR  = q.b0[15:8];
  assign WR_DATA  = q.b0[7:0];
  assign RD_ADDR  = q.ptr;

  a_ack_on_match: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (scl_fall && !start_c && !stop_c && q.st == rtcsra_pkg::ST_ID && !q.ack_slot
     && q.bcnt == rtcsra_pkg::BIT_ACK && q.shf[7:1] == rtcsra_pkg::TARGET_ID) |=> SDA_OE)
    else $error("matching id byte not acknowledged");
  a_no_ack_miss: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (scl_fall && !start_c && !stop_c && q.st == rtcsra_pkg::ST_ID && !q.ack_slot
     && q.bcnt == rtcsra_pkg::BIT_ACK && q.shf[7:1] != rtcsra_pkg::TARGET_ID) |=> !SDA_OE)
    else $error("foreign id byte acknowledged");
  a_ptr_wrap: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (q.st == rtcsra_pkg::ST_RDAT && q.ptr == rtcsra_pkg::PTR_LAST && scl_fall && !start_c && !stop_c
     && q.bcnt == rtcsra_pkg::BIT_ACK) |=> (RD_ADDR == rtcsra_pkg::PTR_RESET))
    else $error("pointer did not wrap");
  a_ptr_step: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (q.st == rtcsra_pkg::ST_RDAT && q.ptr < rtcsra_pkg::PTR_LAST && scl_fall && !start_c && !stop_c
     && q.bcnt == rtcsra_pkg::BIT_ACK) |=> (RD_ADDR == $past(RD_ADDR) + 8'h01))
    else $error("pointer did not step by one");
  a_rel_ack: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (q.st == rtcsra_pkg::ST_RACK) |-> !SDA_OE)
    else $error("line held during controller acknowledge");
  a_stop_idle: assert property (@(posedge SYS_CLK) disable iff (SRST)
    stop_c |=> (q.st == rtcsra_pkg::ST_IDLE && !SDA_OE))
    else $error("stop did not idle engine");
  a_nack_ends: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (q.st == rtcsra_pkg::ST_RACK && scl_rise && q.sda_f && !stop_c && !start_c)
    |=> q.st == rtcsra_pkg::ST_IDLE ##1 !SDA_OE)
    else $error("read continued after no acknowledge");
  a_ack_goes_on: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (q.st == rtcsra_pkg::ST_RACK && scl_rise && !q.sda_f && !stop_c && !start_c)
    |=> q.st == rtcsra_pkg::ST_RDAT)
    else $error("read stopped after controller acknowledge");
  a_addr_load: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (q.st == rtcsra_pkg::ST_ADDR && scl_fall && !q.ack_slot && !start_c && !stop_c
     && q.bcnt == rtcsra_pkg::BIT_ACK) |=> (RD_ADDR == $past(q.shf)))
    else $error("pointer not loaded from address byte");
  a_wr_push: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (q.st == rtcsra_pkg::ST_WDAT && scl_fall && !q.ack_slot && !start_c && !stop_c
     && q.bcnt == rtcsra_pkg::BIT_ACK && !q.bv[0]) |=> (WR_VALID && WR_DATA == $past(q.shf)))
    else $error("written byte not buffered");
endmodule

/* include/rtcsra_pkg.sv */
package rtcsra_pkg;
  // target identifier compared against the upper seven bits of the first byte
  localparam logic [6:0] TARGET_ID    = 7'h6F;
  // last register location before the pointer rolls over
  localparam logic [7:0] PTR_LAST     = 8'h13;
  localparam logic [7:0] PTR_RESET    = 8'h00;
  localparam int         REG_COUNT    = 20;
  localparam logic [3:0] BIT_RESET    = 4'h0;
  localparam logic [3:0] BIT_ACK      = 4'h8;
  // engine states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_ID   = 6'b000010,
    ST_ADDR = 6'b000100,
    ST_WDAT = 6'b001000,
    ST_RDAT = 6'b010000,
    ST_RACK = 6'b100000
  } rtcsra_state_t;
endpackage

/* testbench/rtcsra_master.sv */
`timescale 1ns/10ps
// bus controller model: drives the clock, pulls data low (open drain)
module rtcsra_master
(
  // bus lines
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  localparam time Q = 40; // quarter of the 160 ns bus period
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // start or repeated start: data falls while the clock is high
  task automatic start_c();
    sda_low = 1'b0;
    #Q scl = 1'b1;
    #Q sda_low = 1'b1;
    #Q scl = 1'b0;
    #Q;
  endtask
  // stop: data rises while the clock is high; clock then stands high
  task automatic stop_c();
    sda_low = 1'b1;
    #Q scl = 1'b1;
    #Q sda_low = 1'b0;
    #Q;
  endtask
  // one clock; the line is sampled mid-high, well after the far side settles
  task automatic pulse(output logic lvl);
    #Q scl = 1'b1;
    #Q lvl = sda;
    #Q scl = 1'b0;
    #Q;
  endtask
  // send a byte, then release the line and sample the acknowledge
  task automatic send(input logic [7:0] b, output logic ack);
    logic lvl;
    for (int i = 7; i >= 0; i--)
    begin
      sda_low = ~b[i];
      pulse(lvl);
    end
    sda_low = 1'b0;
    pulse(lvl);
    ack = ~lvl;
  endtask
  // receive a byte, then acknowledge (continue) or not (last byte)
  task automatic recv(input logic ack, output logic [7:0] b);
    logic lvl;
    sda_low = 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      pulse(lvl);
      b[i] = lvl;
    end
    sda_low = ack;
    pulse(lvl);
    sda_low = 1'b0;
  endtask
endmodule

/* testbench/rtcsra_bench.sv */
`timescale 1ns/10ps
// random writes and reads through the controller model, with corner cases
module rtcsra_bench;
  logic        SYS_CLK;
  logic        SRST;
  logic        WR_READY;
  logic        stall;
  logic        sda_low;
  logic        scl;
  logic        oe;
  logic        so;
  logic        wv;
  logic [7:0]  wa;
  logic [7:0]  wd;
  logic [7:0]  ra;
  logic [7:0]  ptr;
  logic [7:0]  mem [20];
  logic [15:0] pend [$];
  logic [7:0]  ctl_bad [4] = '{8'h5E, 8'hCE, 8'hDA, 8'hFE};
  int          errors;
  int          checks;
  integer      seed = 32'hD47F;
  wire         sda = ~(sda_low | oe); // pull-up; device only pulls low
  wire  [7:0]  rdd = (ra < 8'h14) ? mem[ra[4:0]] : 8'hFF;
  rtcsra_top DUT (.SYS_CLK(SYS_CLK), .SRST(SRST), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(so), .SDA_OE(oe),
    .WR_VALID(wv), .WR_READY(WR_READY), .WR_ADDR(wa), .WR_DATA(wd), .RD_ADDR(ra), .RD_DATA(rdd));
  rtcsra_master ctl (.scl(scl), .sda_low(sda_low), .sda(sda));
  initial
  begin
    SYS_CLK = 1'b0;
    forever #2.5 SYS_CLK = ~SYS_CLK;
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up();
    if (errors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // pointer after one transmitted byte: rolls over after the last location
  function automatic logic [7:0] nxt(input logic [7:0] p);
    return (p == 8'h13) ? 8'h00 : p + 8'h01;
  endfunction
  // register sink: random stalls; each taken word must be the oldest write
  always @(negedge SYS_CLK)
    WR_READY <= ~stall & 1'($random(seed));
  always @(posedge SYS_CLK)
    if (!SRST && wv && WR_READY)
    begin
      chk("write pending", 8'h01, {7'h00, pend.size() != 0});
      chk("write address", pend[0][15:8], wa);
      chk("write data", pend[0][7:0], wd);
      mem[pend[0][12:8]] = pend[0][7:0];
      void'(pend.pop_front());
    end
  task automatic wr(input logic [7:0] id, input logic [7:0] a, input logic [7:0] d, input logic dack);
    logic ack;
    ctl.start_c();
    ctl.send(id, ack);
    chk("id ack", {7'h00, id[7:1] == 7'h6F}, {7'h00, ack});
    if (ack)
    begin
      ctl.send(a, ack);
      chk("address ack", 8'h01, {7'h00, ack});
      if (dack)
        pend.push_back({a, d});
      ctl.send(d, ack);
      chk("data ack", {7'h00, dack}, {7'h00, ack});
    end
    ctl.stop_c();
  endtask
  // read n bytes; with set the pointer is first loaded by a dummy write
  task automatic rd(input logic [7:0] a, input int n, input logic set);
    logic       ack;
    logic [7:0] b;
    ctl.start_c();
    if (set)
    begin
      ctl.send(8'hDE, ack);
      chk("id ack", 8'h01, {7'h00, ack});
      ctl.send(a, ack);
      chk("address ack", 8'h01, {7'h00, ack});
      ptr = a;
      ctl.start_c();
    end
    ctl.send(8'hDF, ack);
    chk("read id ack", 8'h01, {7'h00, ack});
    for (int i = 0; i < n; i++)
    begin
      ctl.recv(i < n - 1, b);
      chk("read data", mem[ptr[4:0]], b);
      ptr = nxt(ptr);
    end
    ctl.stop_c();
  endtask
  task automatic drain();
    for (int n = 0; n < 3000 && pend.size() != 0; n++)
      @(negedge SYS_CLK);
    if (pend.size() != 0)
    begin
      chk("write drain", 8'h00, 8'h01);
      wrap_up();
    end
  endtask
  // main sequence
  initial
  begin
    SRST = 1'b1;
    WR_READY = 1'b0;
    stall = 1'b0;
    errors = 0;
    checks = 0;
    ptr = 8'h00;
    foreach (mem[i])
      mem[i] = 8'($random(seed));
    repeat (4) @(negedge SYS_CLK);
    SRST = 1'b0;
    repeat (4) @(negedge SYS_CLK);
    chk("pointer after reset", 8'h00, ra);
    chk("data out level", 8'h00, {7'h00, so});
    rd(8'h00, 2, 1'b0);
    for (int k = 0; k < 6; k++)
    begin
      wr(8'hDE, 8'($unsigned($random(seed)) % 20), 8'($random(seed)), 1'b1);
      drain();
    end
    foreach (ctl_bad[i])
      wr(ctl_bad[i], 8'h01, 8'h55, 1'b0);
    wr(8'hDE, 8'h13, 8'($random(seed)), 1'b1);
    drain();
    rd(8'h12, 5, 1'b1);
    rd(8'($unsigned($random(seed)) % 20), 3, 1'b1);
    rd(8'h00, 2, 1'b0);
    stall = 1'b1;
    wr(8'hDE, 8'h02, 8'hA5, 1'b1);
    wr(8'hDE, 8'h03, 8'h5A, 1'b1);
    wr(8'hDE, 8'h04, 8'h3C, 1'b0);
    stall = 1'b0;
    drain();
    rd(8'h02, 3, 1'b1);
    wrap_up();
  end
  initial
  begin
    repeat (100000) @(posedge SYS_CLK);
    errors++;
    wrap_up();
  end
endmodule
